// >>> mode_ctrl_defs.svh
// constants for the chip mode and low-power controller
`ifndef MODE_CTRL_DEFS_SVH
`define MODE_CTRL_DEFS_SVH
`define MODE_SEL_W        2
`define MODE_SEL_SINGLE   2'h0
`define MODE_SEL_EXPANDED 2'h1
`define MODE_SEL_DFBOOT   2'h2
`define LP_REQ_NONE       2'h0
`define LP_REQ_STOP       2'h1
`define LP_REQ_PSTOP      2'h2
`define LP_REQ_DOZE       2'h3
`define SETTLE_TIME_NS    100
`define CLK_PERIOD_NS     20
`define SETTLE_CYCLES     ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) \
                           / `CLK_PERIOD_NS)
`endif

// >>> mode_ctrl_pkg.sv
// types for the chip mode and low-power controller
package mode_ctrl_pkg;
   typedef enum logic [5:0] {
      MODE_NORM_SINGLE = 6'h01,
      MODE_NORM_EXP    = 6'h02,
      MODE_SEC_SINGLE  = 6'h04,
      MODE_SEC_EXP     = 6'h08,
      MODE_NORM_DFBOOT = 6'h10,
      MODE_SEC_DFBOOT  = 6'h20
   } chip_mode_t;
   typedef enum logic [2:0] {
      BOOT_PFLASH = 3'h1,
      BOOT_DFLASH = 3'h2,
      BOOT_EXTBUS = 3'h4
   } boot_src_t;
   typedef struct packed {
      boot_src_t boot_src;
      logic      debug_en;
      logic      ext_bus_en;
      logic      flash_access_en;
      logic      lockout_recovery_en;
      logic      pins_to_ext_bus;
      logic      pins_gpio_input;
   } mode_cfg_t;
   typedef struct packed {
      logic core_clk_en;
      logic bus_clk_en;
      logic periph_clk_en;
      logic osc_en;
      logic watchdog_clk_en;
      logic wakeup_timer_clk_en;
   } clk_gate_t;
endpackage

// >>> sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clock_in,
   input  wire logic         rst_b_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;
   // next values: first stage feeds only the second
   always_comb begin
      meta_nxt = d_in;
      q_nxt    = meta_r;
   end
   // register both stages
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r    <= q_nxt;
      end
   end
   assign q_out = q_r;
endmodule
`default_nettype wire

// >>> mode_decode.sv
// decode of the latched chip mode into configuration
`timescale 1ns/1ps
`default_nettype none
module mode_decode (
   // mode
   input  wire mode_ctrl_pkg::chip_mode_t mode_in,
   // configuration
   output mode_ctrl_pkg::mode_cfg_t       cfg_out
);
   import mode_ctrl_pkg::*;
   // mode to feature table
   always_comb begin
      cfg_out = '0;
      cfg_out.boot_src = BOOT_PFLASH;
      unique case (mode_in)
         MODE_NORM_SINGLE: begin
            cfg_out.boot_src = BOOT_PFLASH;
            cfg_out.debug_en = 1'b1;
            cfg_out.ext_bus_en = 1'b1;
            cfg_out.flash_access_en = 1'b1;
         end
         MODE_NORM_EXP: begin
            cfg_out.boot_src = BOOT_EXTBUS;
            cfg_out.debug_en = 1'b1;
            cfg_out.ext_bus_en = 1'b1;
            cfg_out.flash_access_en = 1'b1;
            cfg_out.pins_to_ext_bus = 1'b1;
         end
         MODE_SEC_SINGLE: begin
            cfg_out.boot_src = BOOT_PFLASH;
            cfg_out.debug_en = 1'b0;
            cfg_out.ext_bus_en = 1'b0;
            cfg_out.flash_access_en = 1'b1;
            cfg_out.lockout_recovery_en = 1'b1;
         end
         MODE_SEC_EXP: begin
            cfg_out.boot_src = BOOT_EXTBUS;
            cfg_out.debug_en = 1'b1;
            cfg_out.ext_bus_en = 1'b1;
            cfg_out.flash_access_en = 1'b0;
            cfg_out.pins_to_ext_bus = 1'b1;
         end
         MODE_NORM_DFBOOT: begin
            cfg_out.boot_src = BOOT_DFLASH;
            cfg_out.debug_en = 1'b1;
            cfg_out.ext_bus_en = 1'b1;
            cfg_out.flash_access_en = 1'b1;
         end
         MODE_SEC_DFBOOT: begin
            cfg_out.boot_src = BOOT_DFLASH;
            cfg_out.debug_en = 1'b0;
            cfg_out.ext_bus_en = 1'b0;
            cfg_out.flash_access_en = 1'b1;
            cfg_out.lockout_recovery_en = 1'b1;
         end
         default: begin
            cfg_out.boot_src = BOOT_PFLASH;
         end
      endcase
      // every non-expanded mode leaves pins as plain inputs
      cfg_out.pins_gpio_input = ~cfg_out.pins_to_ext_bus;
   end
endmodule
`default_nettype wire

// >>> chip_mode_and_low_power_control.sv
// chip mode selection and low-power sequencing
// Operation
// - Six modes are picked after reset release from mode pins and flash security.
// - Debug is off in secured single-chip and data-flash boot, else on.
// - Each mode pair boots from program flash, data flash or external bus.
// - Secured single-chip and data-flash boot have no external bus.
// - Debug lockout recovery is offered in those two secured modes.
// - Normal expanded mode keeps both flashes reachable.
// - Secured expanded mode blocks both flashes but keeps debug.
// - Stop mode gates every clock of the controller.
// - On stop all modules acknowledge first and only then do clocks stop.
// - Pseudo-stop keeps the oscillator while gating most clocks.
// - In pseudo-stop watchdog and wake-up timer run only when enabled.
// - Doze keeps the bus clock and broadcasts one doze request.
// - Outside the expanded modes all pins reset to general inputs.
// - In expanded modes some pins belong to the external bus controller.
`include "mode_ctrl_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module chip_mode_and_low_power_control #(
   parameter int NUM_MODULES = 8
) (
   // clock and reset
   input  wire logic                      clock_in,
   input  wire logic                      rst_b_in,
   // mode selection pins and flash security state
   input  wire logic [`MODE_SEL_W-1:0]    mode_sel_in,
   input  wire logic                      flash_secure_in,
   // low-power request from the core, same clock
   input  wire logic [1:0]                lp_req_in,
   input  wire logic                      wake_in,
   input  wire logic                      watchdog_en_in,
   input  wire logic                      wakeup_timer_en_in,
   // handshake with modules
   input  wire logic [NUM_MODULES-1:0]    stop_ack_in,
   output logic                           stop_req_out,
   output logic                           doze_req_out,
   // chip configuration
   output mode_ctrl_pkg::chip_mode_t      mode_out,
   output mode_ctrl_pkg::mode_cfg_t       cfg_out,
   // clock gating to the clock generator
   output mode_ctrl_pkg::clk_gate_t       clk_gate_out,
   output logic                           lp_active_out
);
   import mode_ctrl_pkg::*;

   typedef enum logic [5:0] {
      ST_RUN      = 6'h01,
      ST_STOP_REQ = 6'h02,
      ST_STOPPED  = 6'h04,
      ST_PSTOP    = 6'h08,
      ST_DOZE     = 6'h10,
      ST_WAKE     = 6'h20
   } lp_state_t;

   localparam logic [3:0] SETTLE_CNT = 4'(`SETTLE_CYCLES);

   logic [`MODE_SEL_W-1:0] mode_sel_s;
   logic                   secure_s;
   logic                   latch_done_r;
   logic                   latch_done_nxt;
   chip_mode_t             mode_r;
   chip_mode_t             mode_nxt;
   lp_state_t              state_r;
   lp_state_t              state_nxt;
   logic [3:0]             cnt_r;
   logic [3:0]             cnt_nxt;
   clk_gate_t              gate_r;
   clk_gate_t              gate_nxt;
   logic                   all_ack;
   mode_cfg_t              dec_cfg;
   mode_cfg_t              cfg_r;
   mode_cfg_t              cfg_nxt;
   logic                   lp_active_r;
   logic                   lp_active_nxt;

   // external mode pins and security pass two flip-flops
   sync2 #(
      .W (`MODE_SEL_W + 1)
   ) u_sync (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .d_in     ({mode_sel_in, flash_secure_in}),
      .q_out    ({mode_sel_s, secure_s})
   );

   // lookup on the value being latched, so the decode registers with it
   mode_decode u_dec (
      .mode_in (mode_nxt),
      .cfg_out (dec_cfg)
   );

   // configuration follows the decode of the next mode
   always_comb begin
      cfg_nxt = dec_cfg;
   end

   // mode capture once the synchronised pins are valid after release
   always_comb begin
      mode_nxt       = mode_r;
      latch_done_nxt = latch_done_r;
      cnt_nxt        = cnt_r;
      if (!latch_done_r) begin
         if (cnt_r != SETTLE_CNT) begin
            cnt_nxt = cnt_r + 4'h1;
         end else begin
            latch_done_nxt = 1'b1;
            unique case (mode_sel_s)
               `MODE_SEL_EXPANDED: begin
                  mode_nxt = secure_s ? MODE_SEC_EXP : MODE_NORM_EXP;
               end
               `MODE_SEL_DFBOOT: begin
                  mode_nxt = secure_s ? MODE_SEC_DFBOOT : MODE_NORM_DFBOOT;
               end
               default: begin
                  mode_nxt = secure_s ? MODE_SEC_SINGLE : MODE_NORM_SINGLE;
               end
            endcase
         end
      end
   end

   // register the captured mode
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mode_r       <= MODE_NORM_SINGLE;
         latch_done_r <= 1'b0;
         cnt_r        <= 4'h0;
         // same as the decode of the reset mode
         cfg_r        <= '{boot_src: BOOT_PFLASH, debug_en: 1'b1,
                           ext_bus_en: 1'b1, flash_access_en: 1'b1,
                           lockout_recovery_en: 1'b0,
                           pins_to_ext_bus: 1'b0, pins_gpio_input: 1'b1};
      end else begin
         mode_r       <= mode_nxt;
         cfg_r        <= cfg_nxt;
         latch_done_r <= latch_done_nxt;
         cnt_r        <= cnt_nxt;
      end
   end

   assign all_ack = &stop_ack_in;

   // low-power sequencer next state and clock gates
   always_comb begin
      state_nxt = state_r;
      gate_nxt  = '{core_clk_en: 1'b1, bus_clk_en: 1'b1,
                    periph_clk_en: 1'b1, osc_en: 1'b1,
                    watchdog_clk_en: 1'b1, wakeup_timer_clk_en: 1'b1};
      unique case (state_r)
         ST_RUN: begin
            if (latch_done_r) begin
               unique case (lp_req_in)
                  `LP_REQ_STOP:  state_nxt = ST_STOP_REQ;
                  `LP_REQ_PSTOP: state_nxt = ST_STOP_REQ;
                  `LP_REQ_DOZE:  state_nxt = ST_DOZE;
                  default:       state_nxt = ST_RUN;
               endcase
            end
         end
         ST_STOP_REQ: begin
            // clocks stay on until every module has acknowledged
            if (all_ack) begin
               state_nxt = (lp_req_in == `LP_REQ_PSTOP) ? ST_PSTOP
                                                        : ST_STOPPED;
            end else if (wake_in) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_STOPPED: begin
            gate_nxt = '0;
            if (wake_in) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_PSTOP: begin
            gate_nxt = '0;
            gate_nxt.osc_en = 1'b1;
            gate_nxt.watchdog_clk_en = watchdog_en_in;
            gate_nxt.wakeup_timer_clk_en = wakeup_timer_en_in;
            if (wake_in) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_DOZE: begin
            // bus clock kept; peripherals choose for themselves
            if (wake_in || lp_req_in != `LP_REQ_DOZE) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_WAKE: begin
            // wait for the request to drop before a new entry
            if (lp_req_in == `LP_REQ_NONE) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
      if (state_nxt == ST_STOPPED || state_nxt == ST_PSTOP) begin
         gate_nxt = '0;
         gate_nxt.osc_en = (state_nxt == ST_PSTOP);
         gate_nxt.watchdog_clk_en = (state_nxt == ST_PSTOP) && watchdog_en_in;
         gate_nxt.wakeup_timer_clk_en = (state_nxt == ST_PSTOP)
                                        && wakeup_timer_en_in;
      end
      // busy flag registered from the state being entered
      lp_active_nxt = (state_nxt != ST_RUN);
   end

   // register sequencer state and gates
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r     <= ST_RUN;
         gate_r      <= '1;
         lp_active_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         gate_r      <= gate_nxt;
         lp_active_r <= lp_active_nxt;
      end
   end

   // outputs
   assign stop_req_out  = (state_r == ST_STOP_REQ) || (state_r == ST_STOPPED)
                          || (state_r == ST_PSTOP);
   assign doze_req_out  = (state_r == ST_DOZE);
   assign mode_out      = mode_r;
   assign cfg_out       = cfg_r;
   assign clk_gate_out  = gate_r;
   assign lp_active_out = lp_active_r;
endmodule
`default_nettype wire

// >>> mode_ctrl_sva.sv
// assertion checker for the chip mode and low-power controller
`include "mode_ctrl_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl_sva
   import mode_ctrl_pkg::*;
#(
   parameter int NUM_MODULES = 8
) (
   // clock and reset
   input wire logic                      clock_in,
   input wire logic                      rst_b_in,
   // requests and handshake
   input wire logic [1:0]                lp_req_in,
   input wire logic                      wake_in,
   input wire logic                      watchdog_en_in,
   input wire logic                      wakeup_timer_en_in,
   input wire logic [NUM_MODULES-1:0]    stop_ack_in,
   input wire logic                      stop_req_out,
   input wire logic                      doze_req_out,
   // configuration and gating
   input wire mode_ctrl_pkg::chip_mode_t mode_out,
   input wire mode_ctrl_pkg::mode_cfg_t  cfg_out,
   input wire mode_ctrl_pkg::clk_gate_t  clk_gate_out
);
   logic       sec_lock;
   logic       exp_mode;
   logic [3:0] age_r;
   logic [3:0] age_nxt;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // mode classes
   assign sec_lock = mode_out inside {MODE_SEC_SINGLE, MODE_SEC_DFBOOT};
   assign exp_mode = mode_out inside {MODE_NORM_EXP, MODE_SEC_EXP};
   // cycles since reset release, saturating
   always_comb age_nxt = (age_r == 4'hF) ? age_r : age_r + 4'h1;
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) age_r <= 4'h0;
      else age_r <= age_nxt;
   end
   // stop steps: waiting for acks, all acks in
   sequence s_waiting;
      stop_req_out && !(&stop_ack_in);
   endsequence
   sequence s_acked(logic [1:0] kind);
      stop_req_out && (&stop_ack_in) && lp_req_in == kind && !wake_in;
   endsequence
   mode_onehot_a: assert property ($onehot(mode_out))
      else $error("mode not one of six");
   debug_gate_a: assert property (cfg_out.debug_en == !sec_lock)
      else $error("debug enable wrong for mode");
   boot_map_a: assert property (
      cfg_out.boot_src == (exp_mode ? BOOT_EXTBUS :
      mode_out inside {MODE_NORM_DFBOOT, MODE_SEC_DFBOOT} ? BOOT_DFLASH :
      BOOT_PFLASH)) else $error("boot source wrong for mode");
   ext_bus_a: assert property (sec_lock |-> !cfg_out.ext_bus_en)
      else $error("external bus open in secured mode");
   recovery_a: assert property (
      sec_lock |-> cfg_out.lockout_recovery_en)
      else $error("lockout recovery missing");
   flash_exp_a: assert property (exp_mode |->
      cfg_out.flash_access_en == (mode_out == MODE_NORM_EXP))
      else $error("flash access wrong in expanded mode");
   pin_own_a: assert property (
      cfg_out.pins_gpio_input == !exp_mode &&
      cfg_out.pins_to_ext_bus == exp_mode) else $error("pin ownership wrong");
   mode_hold_a: assert property (
      age_r == 4'hF |-> $stable(mode_out))
      else $error("mode changed after latch");
   ack_wait_a: assert property (s_waiting |=> clk_gate_out.core_clk_en)
      else $error("clocks stopped before all acks");
   stop_all_a: assert property (
      s_acked(`LP_REQ_STOP) |=> clk_gate_out == '0)
      else $error("stop left a clock running");
   pstop_keep_a: assert property (s_acked(`LP_REQ_PSTOP) |=>
      !clk_gate_out.core_clk_en && clk_gate_out.osc_en &&
      clk_gate_out.watchdog_clk_en == $past(watchdog_en_in) &&
      clk_gate_out.wakeup_timer_clk_en == $past(wakeup_timer_en_in))
      else $error("pseudo-stop gating wrong");
   doze_bus_a: assert property (
      doze_req_out |-> clk_gate_out.bus_clk_en &&
      $past(lp_req_in) == `LP_REQ_DOZE) else $error("doze without bus clock");
endmodule
bind chip_mode_and_low_power_control mode_ctrl_sva #(
   .NUM_MODULES(NUM_MODULES)) sva (.clock_in(clock_in), .rst_b_in(rst_b_in),
   .lp_req_in(lp_req_in), .wake_in(wake_in), .watchdog_en_in(watchdog_en_in),
   .wakeup_timer_en_in(wakeup_timer_en_in), .stop_ack_in(stop_ack_in),
   .stop_req_out(stop_req_out), .doze_req_out(doze_req_out),
   .mode_out(mode_out), .cfg_out(cfg_out), .clk_gate_out(clk_gate_out));
`default_nettype wire

// >>> periph_model.sv
// stop acknowledge and doze response model of the peripheral modules
`timescale 1ns/1ps
`default_nettype none
module periph_model #(
   parameter int NUM_MODULES = 8
) (
   // clock and reset
   input  wire logic                   clock_in,
   input  wire logic                   rst_b_in,
   // requests and settings
   input  wire logic                   stop_req_in,
   input  wire logic                   doze_req_in,
   input  wire logic [7:0]             ack_delay_in,
   input  wire logic [NUM_MODULES-1:0] doze_en_in,
   // responses
   output logic      [NUM_MODULES-1:0] stop_ack_out,
   output logic      [NUM_MODULES-1:0] asleep_out
);
   int wait_r;
   // cycles spent settling since the stop request rose
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) wait_r <= 0;
      else wait_r <= stop_req_in ? wait_r + 1 : 0;
   end
   // module i is settled one cycle after module i-1, then acks
   always_comb begin
      for (int i = 0; i < NUM_MODULES; i++) begin
         stop_ack_out[i] = stop_req_in && wait_r > int'(ack_delay_in) + i;
      end
   end
   // each peripheral sleeps only when its own doze enable is set
   assign asleep_out = doze_en_in & {NUM_MODULES{doze_req_in}};
endmodule
`default_nettype wire

// >>> tb_chip_mode_and_low_power_control.sv
// testbench for the chip mode and low-power controller
`include "mode_ctrl_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_chip_mode_and_low_power_control;
   import mode_ctrl_pkg::*;
   logic clock_in, rst_b_in, flash_secure_in, wake_in, stop_req_out;
   logic watchdog_en_in, wakeup_timer_en_in, doze_req_out, lp_active_out;
   logic [1:0] mode_sel_in, lp_req_in;
   logic [7:0] ack_dly, stop_ack_in, asleep;
   chip_mode_t mode_out;
   mode_cfg_t  cfg_out;
   clk_gate_t  clk_gate_out;
   int errors, n_tests;
   chip_mode_and_low_power_control #(.NUM_MODULES(8)) dut (
      .clock_in(clock_in), .rst_b_in(rst_b_in), .mode_sel_in(mode_sel_in),
      .flash_secure_in(flash_secure_in), .lp_req_in(lp_req_in),
      .wake_in(wake_in), .watchdog_en_in(watchdog_en_in),
      .wakeup_timer_en_in(wakeup_timer_en_in), .stop_ack_in(stop_ack_in),
      .stop_req_out(stop_req_out), .doze_req_out(doze_req_out),
      .mode_out(mode_out), .cfg_out(cfg_out), .clk_gate_out(clk_gate_out),
      .lp_active_out(lp_active_out));
   periph_model #(.NUM_MODULES(8)) peer (.clock_in(clock_in),
      .rst_b_in(rst_b_in), .stop_req_in(stop_req_out),
      .doze_req_in(doze_req_out), .ack_delay_in(ack_dly),
      .doze_en_in(8'h5A), .stop_ack_out(stop_ack_in), .asleep_out(asleep));
   // 50 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   task automatic step(int n);
      repeat (n) @(posedge clock_in);
      #2;
   endtask
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // reset with given pins, then wait until the mode is latched
   task automatic do_reset(logic [1:0] sel, logic sec);
      rst_b_in = 1'b0;
      mode_sel_in = sel;
      flash_secure_in = sec;
      step(2);
      rst_b_in = 1'b1;
      step(10);
   endtask
   // all six modes and their configuration, then hold after latch
   task automatic t_modes();
      mode_cfg_t  e;
      chip_mode_t m;
      logic       x;
      logic       d;
      for (int s = 0; s < 4; s++) begin
         for (int c = 0; c < 2; c++) begin
            do_reset(2'(s), 1'(c));
            x = (s == 1);
            d = (s == 2);
            m = x ? (c ? MODE_SEC_EXP : MODE_NORM_EXP) :
                d ? (c ? MODE_SEC_DFBOOT : MODE_NORM_DFBOOT) :
                (c ? MODE_SEC_SINGLE : MODE_NORM_SINGLE);
            e.boot_src = x ? BOOT_EXTBUS : d ? BOOT_DFLASH : BOOT_PFLASH;
            e.debug_en = !(c && !x);
            e.ext_bus_en = !(c && !x);
            e.flash_access_en = !(c && x);
            e.lockout_recovery_en = c && !x;
            e.pins_to_ext_bus = x;
            e.pins_gpio_input = !x;
            check("mode", 32'(mode_out), 32'(m));
            check("config", 32'(cfg_out), 32'(e));
            check("pins", 32'({cfg_out.pins_to_ext_bus,
               cfg_out.pins_gpio_input}), 32'({x, !x}));
            check("flash", 32'(cfg_out.flash_access_en),
               32'(!(c && x)));
            mode_sel_in = 2'(s + 1);
            flash_secure_in = !c;
            step(4);
            check("held mode", 32'(mode_out), 32'(m));
         end
      end
      $display("test modes done");
   endtask
   // stop or pseudo-stop entry, gate check, wake and return
   task automatic t_lp(logic [1:0] req, logic [7:0] dly, logic wd, logic tm);
      int k;
      ack_dly = dly;
      watchdog_en_in = wd;
      wakeup_timer_en_in = tm;
      lp_req_in = req;
      for (k = 0; k < 20 && !stop_req_out; k++) step(1);
      if (k == 20) begin
         errors++;
         results();
      end
      step(1);
      check("gate before ack", 32'(clk_gate_out.core_clk_en), 32'h1);
      for (k = 0; k < 40 && clk_gate_out.core_clk_en !== 1'b0; k++) step(1);
      if (k == 40) begin
         errors++;
         results();
      end
      check("stop gates", 32'(clk_gate_out),
         (req == `LP_REQ_STOP) ? 32'h0 : {29'h0, 1'b1, wd, tm});
      check("lp active", 32'(lp_active_out), 32'h1);
      wake_in = 1'b1;
      step(1);
      wake_in = 1'b0;
      lp_req_in = `LP_REQ_NONE;
      step(3);
      check("woken gates", 32'(clk_gate_out), 32'h3F);
      check("stop released", 32'({stop_req_out, lp_active_out}),
         32'h0);
      $display("test low power done");
   endtask
   // wake before all acks: clocks never stop and the request drops
   task automatic t_abort();
      ack_dly = 8'h28;
      lp_req_in = `LP_REQ_STOP;
      step(3);
      check("abort wait", 32'({stop_req_out, lp_active_out}),
         32'h3);
      wake_in = 1'b1;
      step(1);
      check("abort", 32'({stop_req_out, clk_gate_out}), 32'h3F);
      wake_in = 1'b0;
      lp_req_in = `LP_REQ_NONE;
      step(2);
      check("abort idle", 32'(lp_active_out), 32'h0);
      $display("test abort done");
   endtask
   // doze keeps the bus clock and ends when the request drops
   task automatic t_doze();
      lp_req_in = `LP_REQ_DOZE;
      step(2);
      check("doze req", 32'({doze_req_out, stop_req_out}), 32'h2);
      check("doze bus clock", 32'(clk_gate_out.bus_clk_en), 32'h1);
      check("doze sleepers", 32'(asleep), 32'h5A);
      lp_req_in = `LP_REQ_NONE;
      step(2);
      check("doze end", 32'({doze_req_out, asleep}), 32'h0);
      $display("test doze done");
   endtask
   initial begin
      errors = 0;
      n_tests = 0;
      rst_b_in = 1'b0;
      mode_sel_in = 2'h0;
      flash_secure_in = 1'b0;
      lp_req_in = `LP_REQ_NONE;
      wake_in = 1'b0;
      watchdog_en_in = 1'b0;
      wakeup_timer_en_in = 1'b0;
      ack_dly = 8'h0;
      t_modes();
      do_reset(2'h0, 1'b0);
      t_lp(`LP_REQ_STOP, 8'h0, 1'b0, 1'b0);
      t_lp(`LP_REQ_STOP, 8'h6, 1'b1, 1'b1);
      t_lp(`LP_REQ_PSTOP, 8'h2, 1'b1, 1'b0);
      t_lp(`LP_REQ_PSTOP, 8'h4, 1'b0, 1'b1);
      t_abort();
      t_doze();
      results();
   end
endmodule
`default_nettype wire
